// ==== src/capability_regs.sv ====
/*
  Processor capability register bank: the capability setup word and the
  first capability extension word, reachable over an AXI4-Lite slave port.
  Assumes one clock, a synchronous active-high reset held at least five
  edges, and a byte-order strap pin that is stable around reset.
*/
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Setup word bit 31 reads one, extension word exists; writes ignored.
// - With fixed mapping, upper kernel coherency is a writable three-bit field.
// - With fixed mapping, user segment coherency is a writable three-bit field.
// - Without fixed mapping, both segment coherency fields read zero, ignore writes.
// - Nine-bit implementation field is reserved, read-only, value set by parameter.
// - Byte order flag reads the running endian mode, taken from a pin.
// - Preset read-only architecture type and revision fields.
// - Preset read-only translation unit type field.
// - Bits 6 to 4 read zero; software writes zero there.
// - Preset read-only flag tells whether the instruction cache is virtual.
// - First kernel coherency is a writable three-bit field in bits 2 to 0.
// - All other fields are constants or captured during reset.
// - Extension word encodes sets, line size, associativity for both caches.
// - Line size encoding reads zero for a cache that is absent.
module capability_regs
  import capreg_pkg::*;
#(
  parameter logic [1:0] ARCH_TYPE = ARCH_64BIT_FULL,
  parameter logic [2:0] ARCH_REVISION = REV_SECOND,
  parameter logic [2:0] TRANSLATION_TYPE = XLAT_FIXED,
  parameter logic VIRTUAL_ICACHE = 1'h0,
  parameter logic [8:0] IMPL_VALUE = 9'h000,
  parameter logic [5:0] MMU_ENTRIES_M1 = 6'h00,
  parameter logic ICACHE_PRESENT = 1'h1,
  parameter logic [2:0] ICACHE_SETS = 3'h0,
  parameter logic [2:0] ICACHE_LINE = 3'h1,
  parameter logic [2:0] ICACHE_ASSOC = 3'h0,
  parameter logic DCACHE_PRESENT = 1'h1,
  parameter logic [2:0] DCACHE_SETS = 3'h0,
  parameter logic [2:0] DCACHE_LINE = 3'h1,
  parameter logic [2:0] DCACHE_ASSOC = 3'h0,
  parameter logic [6:0] OPTION_BITS = 7'h00
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // Byte-order strap pin.
  input wire logic BYTE_ORDER_PIN,
  // Write address channel.
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic [2:0] AWPROT,
  // Write data channel.
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic [STRB_W-1:0] WSTRB,
  // Write response channel.
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  // Read address channel.
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic [2:0] ARPROT,
  // Read data channel.
  output logic RVALID,
  input wire logic RREADY,
  output logic [DATA_W-1:0] RDATA,
  output logic [1:0] RRESP,
  // Settings driven into the cache and translation logic.
  output logic [2:0] UPPER_KERNEL_COHERENCY,
  output logic [2:0] USER_SEGMENT_COHERENCY,
  output logic [2:0] FIRST_KERNEL_COHERENCY,
  output logic BYTE_ORDER_FLAG
);

  // The segment coherency fields exist only with a fixed-mapping unit.
  localparam logic FIXED_MAP = (TRANSLATION_TYPE == XLAT_FIXED);

  logic strap_level;
  logic byte_order_r;
  logic [2:0] upper_coh_r;
  logic [2:0] user_coh_r;
  logic [2:0] first_coh_r;

  write_state_e wr_state_r;
  logic aw_got_r;
  logic w_got_r;
  write_req_s wr_req_r;
  logic [1:0] bresp_r;

  read_state_e rd_state_r;
  logic [DATA_W-1:0] rdata_r;
  logic [1:0] rresp_r;

  logic aw_fire;
  logic w_fire;
  logic have_aw;
  logic have_w;
  logic commit;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [STRB_W-1:0] wr_strb;
  capability_setup_s wr_fields;
  logic wr_hit_setup;
  logic wr_hit_ext;
  logic ar_fire;
  logic rd_hit_setup;
  logic rd_hit_ext;

  capability_setup_s setup_word;
  capability_extension_one_s ext_word;

  // Strap capture.

  strap_sync u_byte_order_sync (
    .clk(REF_CLK),
    .pin(BYTE_ORDER_PIN),
    .level(strap_level)
  );

  // The mode is sampled while reset is held and then frozen, so a pin
  // that moves later cannot change the byte order under running code.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      byte_order_r <= strap_level;
    end
  end

  // Write path.

  assign AWREADY = (wr_state_r == WS_COLLECT) && !aw_got_r;
  assign WREADY = (wr_state_r == WS_COLLECT) && !w_got_r;
  assign aw_fire = AWVALID && AWREADY;
  assign w_fire = WVALID && WREADY;
  assign have_aw = aw_got_r || aw_fire;
  assign have_w = w_got_r || w_fire;
  assign commit = (wr_state_r == WS_COLLECT) && have_aw && have_w;

  assign wr_addr = aw_got_r ? wr_req_r.addr : AWADDR;
  assign wr_data = w_got_r ? wr_req_r.data : WDATA;
  assign wr_strb = w_got_r ? wr_req_r.strb : WSTRB;
  assign wr_fields = capability_setup_s'(wr_data);

  assign wr_hit_setup = wr_addr[ADDR_W-1:WORD_LSB] == CAP_SETUP_ADDR[ADDR_W-1:WORD_LSB];
  assign wr_hit_ext = wr_addr[ADDR_W-1:WORD_LSB] == CAP_EXT_ONE_ADDR[ADDR_W-1:WORD_LSB];

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wr_state_r <= WS_COLLECT;
    end else begin
      case (wr_state_r)
        WS_COLLECT: begin
          if (commit) begin
            wr_state_r <= WS_RESP;
          end
        end
        WS_RESP: begin
          if (BREADY) begin
            wr_state_r <= WS_COLLECT;
          end
        end
        default: begin
          wr_state_r <= WS_COLLECT;
        end
      endcase
    end
  end

  // A half that arrives alone is parked until its partner shows up.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      aw_got_r <= 1'b0;
    end else if (commit) begin
      aw_got_r <= 1'b0;
    end else if (aw_fire) begin
      aw_got_r <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      w_got_r <= 1'b0;
    end else if (commit) begin
      w_got_r <= 1'b0;
    end else if (w_fire) begin
      w_got_r <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      wr_req_r <= '0;
    end else begin
      if (aw_fire) begin
        wr_req_r.addr <= AWADDR;
      end
      if (w_fire) begin
        wr_req_r.data <= WDATA;
        wr_req_r.strb <= WSTRB;
      end
    end
  end

  // Writes to the extension word are answered but change nothing.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      bresp_r <= RESP_OKAY;
    end else if (commit) begin
      bresp_r <= (wr_hit_setup || wr_hit_ext) ? RESP_OKAY : RESP_DECERR;
    end
  end

  assign BVALID = (wr_state_r == WS_RESP);
  assign BRESP = bresp_r;

  // Coherency fields.
  // Reset clears them to a known code; software still has to program them
  // before enabling caches, since nothing else guarantees a useful value.

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      upper_coh_r <= COH_RESET;
    end else if (commit && wr_hit_setup && FIXED_MAP && wr_strb[LANE_TOP]) begin
      upper_coh_r <= wr_fields.upper_kernel_coherency;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      user_coh_r <= COH_RESET;
    end else if (commit && wr_hit_setup && FIXED_MAP && wr_strb[LANE_TOP]) begin
      user_coh_r <= wr_fields.user_segment_coherency;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      first_coh_r <= COH_RESET;
    end else if (commit && wr_hit_setup && wr_strb[LANE_LOW]) begin
      first_coh_r <= wr_fields.first_kernel_coherency;
    end
  end

  // Word assembly.

  always_comb begin
    setup_word = '0;
    setup_word.ext_present = EXT_ONE_PRESENT;
    setup_word.upper_kernel_coherency = FIXED_MAP ? upper_coh_r : COH_RESET;
    setup_word.user_segment_coherency = FIXED_MAP ? user_coh_r : COH_RESET;
    setup_word.impl_field = IMPL_VALUE;
    setup_word.byte_order_flag = byte_order_r;
    setup_word.architecture_type = ARCH_TYPE;
    setup_word.architecture_revision = ARCH_REVISION;
    setup_word.translation_unit_type = TRANSLATION_TYPE;
    setup_word.reserved_zero = RSVD_ZERO;
    setup_word.virtual_icache_flag = VIRTUAL_ICACHE;
    setup_word.first_kernel_coherency = first_coh_r;
  end

  // Every field here is a constant, so no write can ever reach it.
  always_comb begin
    ext_word = '0;
    ext_word.ext_present = EXT_TWO_PRESENT;
    ext_word.mmu_entries_m1 = MMU_ENTRIES_M1;
    ext_word.icache_sets = ICACHE_SETS;
    ext_word.icache_line = ICACHE_PRESENT ? ICACHE_LINE : LINE_ABSENT;
    ext_word.icache_assoc = ICACHE_ASSOC;
    ext_word.dcache_sets = DCACHE_SETS;
    ext_word.dcache_line = DCACHE_PRESENT ? DCACHE_LINE : LINE_ABSENT;
    ext_word.dcache_assoc = DCACHE_ASSOC;
    {ext_word.cop2_present, ext_word.media_ext_present, ext_word.perf_counters_present,
     ext_word.watch_present, ext_word.code_compress_present, ext_word.debug_present,
     ext_word.fpu_present} = OPTION_BITS;
  end

  // Read path.

  assign ARREADY = (rd_state_r == RS_IDLE);
  assign ar_fire = ARVALID && ARREADY;
  assign rd_hit_setup = ARADDR[ADDR_W-1:WORD_LSB] == CAP_SETUP_ADDR[ADDR_W-1:WORD_LSB];
  assign rd_hit_ext = ARADDR[ADDR_W-1:WORD_LSB] == CAP_EXT_ONE_ADDR[ADDR_W-1:WORD_LSB];

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rd_state_r <= RS_IDLE;
    end else begin
      case (rd_state_r)
        RS_IDLE: begin
          if (ar_fire) begin
            rd_state_r <= RS_DATA;
          end
        end
        RS_DATA: begin
          if (RREADY) begin
            rd_state_r <= RS_IDLE;
          end
        end
        default: begin
          rd_state_r <= RS_IDLE;
        end
      endcase
    end
  end

  // Read data is latched at the address handshake, so a write landing
  // while the answer waits does not alter a word already on offer.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (ar_fire) begin
      if (rd_hit_setup) begin
        rdata_r <= DATA_W'(setup_word);
        rresp_r <= RESP_OKAY;
      end else if (rd_hit_ext) begin
        rdata_r <= DATA_W'(ext_word);
        rresp_r <= RESP_OKAY;
      end else begin
        rdata_r <= '0;
        rresp_r <= RESP_DECERR;
      end
    end
  end

  assign RVALID = (rd_state_r == RS_DATA);
  assign RDATA = rdata_r;
  assign RRESP = rresp_r;

  // Settings out.

  assign UPPER_KERNEL_COHERENCY = setup_word.upper_kernel_coherency;
  assign USER_SEGMENT_COHERENCY = setup_word.user_segment_coherency;
  assign FIRST_KERNEL_COHERENCY = first_coh_r;
  assign BYTE_ORDER_FLAG = byte_order_r;

endmodule
`default_nettype wire

// ==== src/capreg_pkg.sv ====
/*
  Shared constants and types for the processor capability register bank:
  bus address map, field layouts of both capability words, preset encodings,
  bus responses and state codes.
  Assumes a 32-bit AXI4-Lite bus with word-aligned registers.
*/
package capreg_pkg;

  // Bus geometry.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = 4;
  localparam int WORD_LSB = 2;
  localparam int LANE_TOP = 3;
  localparam int LANE_LOW = 0;

  // Register byte addresses.
  localparam logic [ADDR_W-1:0] CAP_SETUP_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] CAP_EXT_ONE_ADDR = 12'h004;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Architecture type codes.
  localparam logic [1:0] ARCH_32BIT = 2'h0;
  localparam logic [1:0] ARCH_64BIT_COMPAT = 2'h1;
  localparam logic [1:0] ARCH_64BIT_FULL = 2'h2;

  // Architecture revision codes.
  localparam logic [2:0] REV_FIRST = 3'h0;
  localparam logic [2:0] REV_SECOND = 3'h1;

  // Translation unit codes.
  localparam logic [2:0] XLAT_NONE = 3'h0;
  localparam logic [2:0] XLAT_TLB = 3'h1;
  localparam logic [2:0] XLAT_BLOCK = 3'h2;
  localparam logic [2:0] XLAT_FIXED = 3'h3;

  // Reset and constant field values.
  localparam logic [2:0] COH_RESET = 3'h0;
  localparam logic [2:0] RSVD_ZERO = 3'h0;
  localparam logic [2:0] LINE_ABSENT = 3'h0;
  localparam logic EXT_ONE_PRESENT = 1'h1;
  localparam logic EXT_TWO_PRESENT = 1'h0;

  // Layout of the capability setup word, most significant field first.
  typedef struct packed {
    logic ext_present;
    logic [2:0] upper_kernel_coherency;
    logic [2:0] user_segment_coherency;
    logic [8:0] impl_field;
    logic byte_order_flag;
    logic [1:0] architecture_type;
    logic [2:0] architecture_revision;
    logic [2:0] translation_unit_type;
    logic [2:0] reserved_zero;
    logic virtual_icache_flag;
    logic [2:0] first_kernel_coherency;
  } capability_setup_s;

  // Layout of the first capability extension word.
  typedef struct packed {
    logic ext_present;
    logic [5:0] mmu_entries_m1;
    logic [2:0] icache_sets;
    logic [2:0] icache_line;
    logic [2:0] icache_assoc;
    logic [2:0] dcache_sets;
    logic [2:0] dcache_line;
    logic [2:0] dcache_assoc;
    logic cop2_present;
    logic media_ext_present;
    logic perf_counters_present;
    logic watch_present;
    logic code_compress_present;
    logic debug_present;
    logic fpu_present;
  } capability_extension_one_s;

  // A write request held between its address and data halves.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [STRB_W-1:0] strb;
  } write_req_s;

  typedef enum logic [1:0] {
    WS_COLLECT = 2'b01,
    WS_RESP = 2'b10
  } write_state_e;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_DATA = 2'b10
  } read_state_e;

endpackage

// ==== src/strap_sync.sv ====
/*
  Three-stage synchroniser for a slowly changing pin level.
  Assumes the pin is quasi-static; a change is accepted once the second and
  third stages agree, so a single-cycle glitch on the third stage is ignored.
*/
`timescale 1ns/1ns
`default_nettype none
module strap_sync (
  // Clock.
  input wire logic clk,
  // Raw pin and accepted level.
  input wire logic pin,
  output logic level
);

  logic stage1_r;
  logic stage2_r;
  logic stage3_r;
  logic level_r;

  // The chain carries data only, so it needs no reset.
  always_ff @(posedge clk) begin
    stage1_r <= pin;
    stage2_r <= stage1_r;
    stage3_r <= stage2_r;
  end

  always_ff @(posedge clk) begin
    if (stage2_r == stage3_r) begin
      level_r <= stage3_r;
    end
  end

  assign level = level_r;

endmodule
`default_nettype wire

// ==== verification/capability_regs_assertions.sv ====
/*
  Concurrent checks on the capability register bank, bound to every instance.
  Assumes the instance parameters describe the presets it reports.
*/
`timescale 1ns/1ns
`default_nettype none
module capability_regs_checker
  import capreg_pkg::*;
#(
  parameter logic [1:0] ARCH_TYPE = ARCH_64BIT_FULL,
  parameter logic [2:0] ARCH_REVISION = REV_SECOND,
  parameter logic [2:0] TRANSLATION_TYPE = XLAT_FIXED,
  parameter logic VIRTUAL_ICACHE = 1'h0,
  parameter logic ICACHE_PRESENT = 1'h1,
  parameter logic DCACHE_PRESENT = 1'h1
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // Bus signals.
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic RVALID,
  input wire logic [DATA_W-1:0] RDATA,
  input wire logic BVALID,
  // Settings.
  input wire logic [2:0] UPPER_KERNEL_COHERENCY,
  input wire logic [2:0] USER_SEGMENT_COHERENCY,
  input wire logic [2:0] FIRST_KERNEL_COHERENCY,
  input wire logic BYTE_ORDER_FLAG
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Word index of the read in flight, since the answer carries no address.
  logic [ADDR_W-3:0] rd_idx_r;
  always_ff @(posedge REF_CLK) begin
    if (ARVALID && ARREADY) begin
      rd_idx_r <= ARADDR[ADDR_W-1:2];
    end
  end
  property p_ext_bit; RVALID && rd_idx_r == '0 |-> RDATA[31]; endproperty
  a_ext_bit: assert property (p_ext_bit) else $error("extension bit low");
  property p_rsvd; RVALID && rd_idx_r == '0 |-> RDATA[6:4] == RSVD_ZERO; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_preset;
    RVALID && rd_idx_r == '0 |-> RDATA[14:3] == {ARCH_TYPE, ARCH_REVISION, TRANSLATION_TYPE, 3'h0, VIRTUAL_ICACHE};
  endproperty
  a_preset: assert property (p_preset) else $error("preset field wrong");
  property p_no_fix;
    TRANSLATION_TYPE != XLAT_FIXED |-> UPPER_KERNEL_COHERENCY == 3'h0 && USER_SEGMENT_COHERENCY == 3'h0;
  endproperty
  a_no_fix: assert property (p_no_fix) else $error("segment coherency not zero");
  property p_kc_cause; !$stable(FIRST_KERNEL_COHERENCY) |-> $rose(BVALID); endproperty
  a_kc_cause: assert property (p_kc_cause) else $error("kernel coherency moved");
  property p_seg_cause;
    !$stable({UPPER_KERNEL_COHERENCY, USER_SEGMENT_COHERENCY}) |-> $rose(BVALID);
  endproperty
  a_seg_cause: assert property (p_seg_cause) else $error("segment coherency moved");
  property p_bo_frozen; !$past(RST) |-> $stable(BYTE_ORDER_FLAG); endproperty
  a_bo_frozen: assert property (p_bo_frozen) else $error("byte order moved");
  property p_line_absent;
    RVALID && rd_idx_r == 'h1 |-> (ICACHE_PRESENT || RDATA[21:19] == LINE_ABSENT)
      && (DCACHE_PRESENT || RDATA[12:10] == LINE_ABSENT);
  endproperty
  a_line_absent: assert property (p_line_absent) else $error("absent cache line size");
  c_write: cover property ($rose(BVALID));
  c_setup_rd: cover property (RVALID && rd_idx_r == '0);
  c_ext_rd: cover property (RVALID && rd_idx_r == 'h1);
endmodule
bind capability_regs capability_regs_checker #(.ARCH_TYPE(ARCH_TYPE), .ARCH_REVISION(ARCH_REVISION),
  .TRANSLATION_TYPE(TRANSLATION_TYPE), .VIRTUAL_ICACHE(VIRTUAL_ICACHE), .ICACHE_PRESENT(ICACHE_PRESENT),
  .DCACHE_PRESENT(DCACHE_PRESENT)) chk (.REF_CLK(REF_CLK), .RST(RST), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .ARADDR(ARADDR), .RVALID(RVALID), .RDATA(RDATA), .BVALID(BVALID),
  .UPPER_KERNEL_COHERENCY(UPPER_KERNEL_COHERENCY), .USER_SEGMENT_COHERENCY(USER_SEGMENT_COHERENCY),
  .FIRST_KERNEL_COHERENCY(FIRST_KERNEL_COHERENCY), .BYTE_ORDER_FLAG(BYTE_ORDER_FLAG));
`default_nettype wire

// ==== verification/capability_regs_test.sv ====
/*
  Self-checking bench for the capability register bank over AXI4-Lite.
  Assumes the checker file is compiled first; a second instance shares the bus.
*/
`timescale 1ns/1ns
`default_nettype none
module capability_regs_test
  import capreg_pkg::*;
;
  logic ref_clk = 1'h0;
  logic rst = 1'h1;
  logic pin = 1'h1;
  // The bank ignores protection bits, so a non-zero code is offered throughout.
  logic [2:0] prot = 3'h5;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic [STRB_W-1:0] wstrb = '0;
  logic awready, wready, bvalid, arready, rvalid, bof;
  logic [1:0] bresp, rresp, resp;
  logic [DATA_W-1:0] rdata, rdata2, rd, rd2;
  logic [2:0] ukc, usc, fkc, usc2;
  int err_count = 0;
  int tests_run = 0;
  int cycles = 0;
  capability_regs dut (.REF_CLK(ref_clk), .RST(rst), .BYTE_ORDER_PIN(pin),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .AWPROT(prot),
    .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
    .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
    .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .ARPROT(prot),
    .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
    .UPPER_KERNEL_COHERENCY(ukc), .USER_SEGMENT_COHERENCY(usc),
    .FIRST_KERNEL_COHERENCY(fkc), .BYTE_ORDER_FLAG(bof));
  // A part without fixed mapping or instruction cache; it follows the same handshakes.
  capability_regs #(.ARCH_TYPE(ARCH_32BIT), .ARCH_REVISION(REV_FIRST), .TRANSLATION_TYPE(XLAT_BLOCK),
    .VIRTUAL_ICACHE(1'h1), .IMPL_VALUE(9'h0a5), .ICACHE_PRESENT(1'h0)) dut2 (
    .REF_CLK(ref_clk), .RST(rst), .BYTE_ORDER_PIN(pin),
    .AWVALID(awvalid), .AWREADY(), .AWADDR(awaddr), .AWPROT(prot),
    .WVALID(wvalid), .WREADY(), .WDATA(wdata), .WSTRB(wstrb),
    .BVALID(), .BREADY(bready), .BRESP(), .ARVALID(arvalid), .ARREADY(), .ARADDR(araddr), .ARPROT(prot),
    .RVALID(), .RREADY(rready), .RDATA(rdata2), .RRESP(), .UPPER_KERNEL_COHERENCY(),
    .USER_SEGMENT_COHERENCY(usc2), .FIRST_KERNEL_COHERENCY(), .BYTE_ORDER_FLAG());
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      err_count++;
      stop_test();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic do_reset(input logic p);
    rst <= 1'h1;
    pin <= p;
    repeat (6) @(posedge ref_clk);
    rst <= 1'h0;
  endtask
  // Readies are sampled mid-cycle so each decision sees the level present at the next edge.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw, w, b;
    b = 1'h0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!b) begin
      @(negedge ref_clk);
      aw = awready;
      w = wready;
      b = bvalid;
      resp = bresp;
      @(posedge ref_clk);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
    end
    bready <= 1'h0;
  endtask
  task automatic rd_word(input logic [11:0] a);
    logic ar, r;
    r = 1'h0;
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!r) begin
      @(negedge ref_clk);
      ar = arready;
      r = rvalid;
      rd = rdata;
      rd2 = rdata2;
      resp = rresp;
      @(posedge ref_clk);
      if (ar) arvalid <= 1'h0;
    end
    rready <= 1'h0;
  endtask
  function automatic logic [31:0] setup_w(input logic [2:0] uk, us, fk, input logic bo);
    return {1'h1, uk, us, 9'h000, bo, ARCH_64BIT_FULL, REV_SECOND, XLAT_FIXED, RSVD_ZERO, 1'h0, fk};
  endfunction
  function automatic logic [31:0] setup2(input logic [2:0] fk, input logic bo);
    return {1'h1, 6'h00, 9'h0a5, bo, ARCH_32BIT, REV_FIRST, XLAT_BLOCK, RSVD_ZERO, 1'h1, fk};
  endfunction
  // Fields: extension flag and entries, I sets, I line, I assoc, D sets, D line, D assoc, options.
  localparam logic [31:0] EXT_EXP = {7'h00, 3'h0, 3'h1, 3'h0, 3'h0, 3'h1, 3'h0, 7'h00};
  localparam logic [31:0] EXT2_EXP = {7'h00, 3'h0, LINE_ABSENT, 3'h0, 3'h0, 3'h1, 3'h0, 7'h00};
  initial begin
    do_reset(1'h1);
    @(posedge ref_clk);
    pin <= 1'h0;
    rd_word(CAP_SETUP_ADDR);
    check("setup", rd, setup_w(3'h0, 3'h0, 3'h0, 1'h1));
    check("setup2", rd2, setup2(3'h0, 1'h1));
    check("byte_order", 32'(bof), 32'h1);
    rd_word(CAP_EXT_ONE_ADDR);
    check("ext", rd, EXT_EXP);
    check("ext2", rd2, EXT2_EXP);
    $display("test reset_state done");
    wr(CAP_SETUP_ADDR, 32'hffff_ffff, 4'hf);
    check("bresp", 32'(resp), 32'(RESP_OKAY));
    check("coherency", {23'h0, ukc, usc, fkc}, 32'h1ff);
    check("user_seg2", 32'(usc2), 32'h0);
    rd_word(CAP_SETUP_ADDR);
    check("setup", rd, setup_w(3'h7, 3'h7, 3'h7, 1'h1));
    check("setup2", rd2, setup2(3'h7, 1'h1));
    wr(CAP_SETUP_ADDR, 32'h0000_0000, 4'h1);
    wr(CAP_SETUP_ADDR, 32'h5200_0000, 4'h8);
    rd_word(CAP_SETUP_ADDR);
    check("setup", rd, setup_w(3'h5, 3'h1, 3'h0, 1'h1));
    $display("test coherency_write done");
    wr(CAP_EXT_ONE_ADDR, 32'hffff_ffff, 4'hf);
    rd_word(CAP_EXT_ONE_ADDR);
    check("ext", rd, EXT_EXP);
    wr(12'h010, 32'hffff_ffff, 4'hf);
    check("bresp", 32'(resp), 32'(RESP_DECERR));
    rd_word(12'h010);
    check("rresp", 32'(resp), 32'(RESP_DECERR));
    check("rdata", rd, 32'h0);
    rd_word(CAP_SETUP_ADDR);
    check("setup", rd, setup_w(3'h5, 3'h1, 3'h0, 1'h1));
    $display("test read_only done");
    do_reset(1'h0);
    rd_word(CAP_SETUP_ADDR);
    check("setup", rd, setup_w(3'h0, 3'h0, 3'h0, 1'h0));
    $display("test second_reset done");
    stop_test();
  end
endmodule
`default_nettype wire
